// >>> design/rdcc_pkg.sv
`default_nettype none
package rdcc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NCH = 8;
    localparam int NLANE = 4;
    localparam int CFG_W = NCH * 8;

    // ------------------------------------------------------------
    // register byte indices
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_SIG = 4'h0;
    localparam logic [3:0] IDX_RSVD = 4'h1;
    localparam logic [3:0] IDX_LBEC = 4'h2;
    localparam logic [3:0] IDX_INDIS = 4'h3;
    localparam logic [3:0] IDX_OUTDIS = 4'h4;
    localparam logic [3:0] IDX_CH_FIRST = 4'h5;
    localparam logic [3:0] IDX_CH_LAST = 4'hC;
    localparam logic [3:0] IDX_VTH = 4'hD;
    localparam logic [3:0] IDX_PWR = 4'hE;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LBEC_LB_LSB = 4;
    localparam int LBEC_WIDTH_A = 3;
    localparam int LBEC_WIDTH_B = 2;
    localparam int LBEC_SLUMBER = 1;
    localparam int LBEC_BYPASS = 0;
    localparam int CH_EQ_LSB = 5;
    localparam int CH_DE_LSB = 3;
    localparam int CH_SW_LSB = 1;
    localparam int PWR_NORMAL = 0;

    // ------------------------------------------------------------
    // encodings and defaults
    // ------------------------------------------------------------
    localparam logic [2:0] EQ_LEAST = 3'h0;
    localparam logic [2:0] EQ_MOST = 3'h7;
    localparam logic [1:0] SWING_1V1 = 2'h0;
    localparam logic [1:0] SWING_0V5 = 2'h1;
    localparam logic [1:0] SWING_0V8 = 2'h2;
    localparam logic [1:0] SWING_1V0 = 2'h3;
    localparam logic [1:0] DE_2DB5 = 2'h0;
    localparam logic [1:0] DE_4DB5 = 2'h1;
    localparam logic [1:0] DE_6DB5 = 2'h2;
    localparam logic [1:0] DE_8DB5 = 2'h3;
    localparam logic WIDTH_FULL = 1'b0;
    localparam logic WIDTH_HALF = 1'b1;
    localparam logic [2:0] DEF_EQ = EQ_MOST;
    localparam logic [1:0] DEF_SWING = SWING_1V0;
    localparam logic [1:0] DEF_DE = DE_8DB5;
    localparam logic DEF_WIDTH = WIDTH_HALF;
    localparam logic [7:0] LBEC_RST = 8'hFE;
    localparam logic [7:0] CH_RST = 8'hFE;
    localparam logic [7:0] DIS_RST = 8'h00;
    localparam logic [7:0] VTH_RST = 8'h10;
    localparam logic [7:0] PWR_RST = 8'h01;
    localparam logic [2:0] INIT_WAIT = 3'h5;

    // ------------------------------------------------------------
    // sampled pins
    // ------------------------------------------------------------
    typedef struct packed {
        logic mode;
        logic lb_n;
        logic pd_n;
        logic width_a;
        logic width_b;
        logic [1:0] level_a;
        logic [1:0] level_b;
        logic [1:0] swing_a;
        logic [1:0] swing_b;
        logic [2:0] eq_a;
        logic [2:0] eq_b;
        logic [7:0] sig;
    } rdcc_pins_t;

    localparam int PINS_W = $bits(rdcc_pins_t);
    localparam logic [PINS_W-1:0] PINS_RST = {19'h7_FFFF, 8'h00};

    // byte bit 7 is channel 0 (a0), bit 0 is channel 7 (b3)
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

endpackage : rdcc_pkg
`default_nettype wire

// >>> design/rdcc_route.sv
`default_nettype none
module rdcc_route #(
    parameter int NLANE = 4
) (
    input wire logic [NLANE-1:0] lane_loopback_n_i,
    input wire logic [2*NLANE-1:0] chan_input_off_i,
    input wire logic [2*NLANE-1:0] chan_output_off_i,
    output logic [2*NLANE-1:0] input_enable_o,
    output logic [NLANE-1:0] a_tx_enable_o,
    output logic [NLANE-1:0] b_tx_enable_o,
    output logic [NLANE-1:0] b_tx_from_a_o
);
    // channel 2l is lane l side a, 2l+1 is side b
    always_comb begin
        input_enable_o = ~chan_input_off_i;
        a_tx_enable_o = '0;
        b_tx_enable_o = '0;
        b_tx_from_a_o = '0;
        for (int l = 0; l < NLANE; l++) begin
            // a transmitter only ever carries a receive data
            a_tx_enable_o[l] = !chan_output_off_i[2*l] && !chan_input_off_i[2*l];
            // loopback with b input off steers a receive to b
            b_tx_from_a_o[l] = !lane_loopback_n_i[l] && chan_input_off_i[2*l+1];
            // unfed or disabled buffers stay idle
            b_tx_enable_o[l] = !chan_output_off_i[2*l+1] &&
                (b_tx_from_a_o[l] ? !chan_input_off_i[2*l] : !chan_input_off_i[2*l+1]);
        end
    end

endmodule : rdcc_route
`default_nettype wire

// >>> design/rdcc_sync.sv
`default_nettype none
module rdcc_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } rdcc_sync_t;

    rdcc_sync_t s_q;
    rdcc_sync_t s_d;

    // a bit moves only once stages two and three agree
    always_comb begin
        s_d = s_q;
        s_d.s1 = async_i;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        s_d.val = (s_q.s2 & ~(s_q.s2 ^ s_q.s3)) | (s_q.val & (s_q.s2 ^ s_q.s3));
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.val;

endmodule : rdcc_sync
`default_nettype wire

// >>> design/rdcc_top.sv
// Behaviour
// - config-source strap is live, never latched
// - strap high: ignore access, use defaults
// - default de-emphasis 8.5dB code 11, half-bit
// - default swing code 11, 1V
// - default equalizer code 111
// - strap low: all control registers writable
// - straps captured into registers at power-on
// - equalizer: three bits, eight rising levels
// - register mode: equalizer per channel
// - strap mode: every channel takes default equalizer code 111
// - swing and de-emphasis shared per group
// - swing codes 1.1, 0.5, 0.8, 1.0V
// - channel bits 4:3 hold de-emphasis level
// - byte 2 bits 3:2 select group widths
// - squelch output while input below threshold
// - threshold one-hot, default bit 4
// - loopback strap acts on all lanes
// - low strap enables loopback, per-lane bits
// - loopback bit 1, none disabled: normal
// - bit 0, only b input off: broadcast
// - disables give loopback, mux and demux
// - byte 2: lane bits 7:4, widths 3:2
// - disable bits switch buffers off
`default_nettype none
module rdcc_top (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic mode_strap_i,
    input wire logic loopback_strap_n_i,
    input wire logic powerdown_strap_n_i,
    input wire logic group_a_deemph_width_i,
    input wire logic group_b_deemph_width_i,
    input wire logic group_a_deemph_level_hi_i,
    input wire logic group_a_deemph_level_lo_i,
    input wire logic group_b_deemph_level_hi_i,
    input wire logic group_b_deemph_level_lo_i,
    input wire logic group_a_swing_hi_i,
    input wire logic group_a_swing_lo_i,
    input wire logic group_b_swing_hi_i,
    input wire logic group_b_swing_lo_i,
    input wire logic [2:0] group_a_eq_sel_i,
    input wire logic [2:0] group_b_eq_sel_i,
    input wire logic [rdcc_pkg::NCH-1:0] sig_detect_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [3:0] reg_idx_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic [3*rdcc_pkg::NCH-1:0] eq_code_o,
    output logic [1:0] group_a_swing_o,
    output logic [1:0] group_b_swing_o,
    output logic [1:0] group_a_deemph_level_o,
    output logic [1:0] group_b_deemph_level_o,
    output logic group_a_deemph_width_o,
    output logic group_b_deemph_width_o,
    output logic [7:0] vth_sel_o,
    output logic [rdcc_pkg::NCH-1:0] squelch_o,
    output logic [rdcc_pkg::NCH-1:0] input_enable_o,
    output logic [rdcc_pkg::NLANE-1:0] a_tx_enable_o,
    output logic [rdcc_pkg::NLANE-1:0] b_tx_enable_o,
    output logic [rdcc_pkg::NLANE-1:0] b_tx_from_a_o,
    output logic powerdown_o,
    output logic slumber_en_o,
    output logic bypass_o
);
    import rdcc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] lbec;
        logic [7:0] indis;
        logic [7:0] outdis;
        logic [CFG_W-1:0] chcfg;
        logic [7:0] vth;
        logic [7:0] pwr;
        logic [2:0] init_cnt;
        logic init_done;
        logic [7:0] rdata;
        logic ack;
        logic [3*NCH-1:0] eq;
        logic [1:0] swa;
        logic [1:0] swb;
        logic [1:0] dla;
        logic [1:0] dlb;
        logic wa;
        logic wb;
        logic [NCH-1:0] squelch;
        logic [NCH-1:0] inen;
        logic [NLANE-1:0] atx;
        logic [NLANE-1:0] btx;
        logic [NLANE-1:0] bfa;
    } rdcc_state_t;

    localparam rdcc_state_t STATE_RST = '{
        lbec: LBEC_RST, indis: DIS_RST, outdis: DIS_RST, chcfg: {NCH{CH_RST}},
        vth: VTH_RST, pwr: PWR_RST, init_cnt: 3'h0, init_done: 1'b0,
        rdata: 8'h00, ack: 1'b0, eq: {NCH{DEF_EQ}}, swa: DEF_SWING, swb: DEF_SWING,
        dla: DEF_DE, dlb: DEF_DE, wa: DEF_WIDTH, wb: DEF_WIDTH,
        squelch: {NCH{1'b1}}, inen: {NCH{1'b1}}, atx: '0, btx: '0, bfa: '0};

    rdcc_state_t s_q;
    rdcc_state_t s_d;
    rdcc_pins_t pins;
    logic [PINS_W-1:0] pins_raw;
    logic [PINS_W-1:0] pins_sync;
    logic access_ok;
    logic [7:0] lbec_rev;
    logic [NCH-1:0] r_inen;
    logic [NLANE-1:0] r_atx;
    logic [NLANE-1:0] r_btx;
    logic [NLANE-1:0] r_bfa;

    function automatic logic [7:0] ch_byte(input logic [CFG_W-1:0] cfg, input int i);
        return cfg[i*8 +: 8];
    endfunction

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    assign pins_raw = {mode_strap_i, loopback_strap_n_i, powerdown_strap_n_i,
        group_a_deemph_width_i, group_b_deemph_width_i,
        group_a_deemph_level_hi_i, group_a_deemph_level_lo_i,
        group_b_deemph_level_hi_i, group_b_deemph_level_lo_i,
        group_a_swing_hi_i, group_a_swing_lo_i, group_b_swing_hi_i, group_b_swing_lo_i,
        group_a_eq_sel_i, group_b_eq_sel_i, sig_detect_i};

    rdcc_sync #(
        .W(PINS_W),
        .RST_VAL(PINS_RST)
    ) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .async_i(pins_raw),
        .sync_o(pins_sync)
    );

    assign pins = rdcc_pins_t'(pins_sync);

    // mode is read live every cycle, no copy is kept
    assign access_ok = !pins.mode && s_q.init_done;

    // ------------------------------------------------------------
    // routing
    // ------------------------------------------------------------
    // lane 0 sits in bit 7, so the byte is flipped before slicing
    assign lbec_rev = rev8(s_q.lbec);

    rdcc_route #(
        .NLANE(NLANE)
    ) u_route (
        .lane_loopback_n_i(lbec_rev[NLANE-1:0]),
        .chan_input_off_i(rev8(s_q.indis)),
        .chan_output_off_i(rev8(s_q.outdis)),
        .input_enable_o(r_inen),
        .a_tx_enable_o(r_atx),
        .b_tx_enable_o(r_btx),
        .b_tx_from_a_o(r_bfa)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] cb;
        cb = 8'h00;
        s_d = s_q;
        s_d.ack = 1'b0;
        // power-on capture waits for the samplers to settle
        if (!s_q.init_done) begin
            s_d.init_cnt = s_q.init_cnt + 3'h1;
            if (s_q.init_cnt == INIT_WAIT) begin
                s_d.init_done = 1'b1;
                s_d.lbec[LBEC_LB_LSB +: NLANE] = {NLANE{pins.lb_n}};
                s_d.lbec[LBEC_WIDTH_A] = pins.width_a;
                s_d.lbec[LBEC_WIDTH_B] = pins.width_b;
                s_d.pwr[PWR_NORMAL] = pins.pd_n;
                for (int i = 0; i < NCH; i++) begin
                    s_d.chcfg[i*8 +: 8] = (i % 2 == 0) ?
                        {pins.eq_a, pins.level_a, pins.swing_a, 1'b0} :
                        {pins.eq_b, pins.level_b, pins.swing_b, 1'b0};
                end
            end
        end
        // register access is dropped without answer in strap mode
        if (access_ok && (reg_wr_i || reg_rd_i)) begin
            s_d.ack = 1'b1;
            s_d.rdata = 8'h00;
            if (reg_wr_i) begin
                // every control byte takes the write, the power byte keeps only bit 0
                case (reg_idx_i)
                    IDX_LBEC: s_d.lbec = reg_wdata_i;
                    IDX_INDIS: s_d.indis = reg_wdata_i;
                    IDX_OUTDIS: s_d.outdis = reg_wdata_i;
                    IDX_VTH: s_d.vth = reg_wdata_i;
                    IDX_PWR: s_d.pwr = reg_wdata_i & PWR_RST;
                    default: begin
                        if (reg_idx_i >= IDX_CH_FIRST && reg_idx_i <= IDX_CH_LAST) begin
                            s_d.chcfg[(reg_idx_i - IDX_CH_FIRST)*8 +: 8] = reg_wdata_i;
                        end
                    end
                endcase
            end else begin
                case (reg_idx_i)
                    IDX_SIG: s_d.rdata = rev8(pins.sig);
                    IDX_RSVD: s_d.rdata = 8'h00;
                    IDX_LBEC: s_d.rdata = s_q.lbec;
                    IDX_INDIS: s_d.rdata = s_q.indis;
                    IDX_OUTDIS: s_d.rdata = s_q.outdis;
                    IDX_VTH: s_d.rdata = s_q.vth;
                    IDX_PWR: s_d.rdata = s_q.pwr;
                    default: begin
                        if (reg_idx_i >= IDX_CH_FIRST && reg_idx_i <= IDX_CH_LAST) begin
                            s_d.rdata = s_q.chcfg[(reg_idx_i - IDX_CH_FIRST)*8 +: 8];
                        end
                    end
                endcase
            end
        end
        // strap mode forces the fixed defaults, registers keep their value
        for (int i = 0; i < NCH; i++) begin
            cb = ch_byte(s_q.chcfg, i);
            s_d.eq[i*3 +: 3] = pins.mode ? DEF_EQ : cb[CH_EQ_LSB +: 3];
        end
        // group swing and de-emphasis come from the group's first channel byte, widths from byte 2
        cb = ch_byte(s_q.chcfg, 0);
        s_d.swa = pins.mode ? DEF_SWING : cb[CH_SW_LSB +: 2];
        s_d.dla = pins.mode ? DEF_DE : cb[CH_DE_LSB +: 2];
        cb = ch_byte(s_q.chcfg, 1);
        s_d.swb = pins.mode ? DEF_SWING : cb[CH_SW_LSB +: 2];
        s_d.dlb = pins.mode ? DEF_DE : cb[CH_DE_LSB +: 2];
        s_d.wa = pins.mode ? DEF_WIDTH : s_q.lbec[LBEC_WIDTH_A];
        s_d.wb = pins.mode ? DEF_WIDTH : s_q.lbec[LBEC_WIDTH_B];
        s_d.squelch = ~pins.sig;
        s_d.inen = r_inen;
        s_d.atx = r_atx;
        s_d.btx = r_btx;
        s_d.bfa = r_bfa;
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_o = s_q.rdata;
    assign reg_ack_o = s_q.ack;
    assign eq_code_o = s_q.eq;
    assign group_a_swing_o = s_q.swa;
    assign group_b_swing_o = s_q.swb;
    assign group_a_deemph_level_o = s_q.dla;
    assign group_b_deemph_level_o = s_q.dlb;
    assign group_a_deemph_width_o = s_q.wa;
    assign group_b_deemph_width_o = s_q.wb;
    assign vth_sel_o = s_q.vth;
    assign squelch_o = s_q.squelch;
    assign input_enable_o = s_q.inen;
    assign a_tx_enable_o = s_q.atx;
    assign b_tx_enable_o = s_q.btx;
    assign b_tx_from_a_o = s_q.bfa;
    // pin and slumber controls never pass the strap mode gate
    assign powerdown_o = !s_q.pwr[PWR_NORMAL];
    assign slumber_en_o = s_q.lbec[LBEC_SLUMBER];
    assign bypass_o = s_q.lbec[LBEC_BYPASS];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_mode_blocks_bus: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        pins.mode && (reg_wr_i || reg_rd_i) |=> !reg_ack_o)
        else $error("access answered in strap mode");

    a_low_mode_answers: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        access_ok && reg_wr_i |=> reg_ack_o)
        else $error("write not answered with strap low");

    a_vth_write_lands: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        access_ok && reg_wr_i && reg_idx_i == IDX_VTH |=> vth_sel_o == $past(reg_wdata_i))
        else $error("threshold write lost");

    a_strap_eq_default: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        pins.mode |=> eq_code_o == {NCH{DEF_EQ}})
        else $error("equalizer not default in strap mode");

    a_strap_out_default: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        pins.mode |=> group_a_swing_o == 2'h3 && group_b_deemph_level_o == 2'h3 && group_a_deemph_width_o)
        else $error("output defaults missing in strap mode");

    a_chan_eq_follows: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !pins.mode |=> eq_code_o[5:3] == $past(s_q.chcfg[15:13]))
        else $error("channel equalizer not from its byte");

    a_squelch_tracks: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !pins.sig[0] |=> squelch_o[0])
        else $error("idle channel not squelched");

    a_init_capture: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(s_q.init_done) |-> s_q.lbec[7] == $past(pins.lb_n) && powerdown_o == !$past(pins.pd_n))
        else $error("straps not captured at start");

    a_normal_route: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        s_q.lbec[7] && !s_q.indis[7] && !s_q.indis[6] && !s_q.outdis[7] && !s_q.outdis[6]
        |=> a_tx_enable_o[0] && b_tx_enable_o[0] && !b_tx_from_a_o[0])
        else $error("lane 0 not in normal routing");

    a_broadcast_route: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !s_q.lbec[7] && !s_q.indis[7] && s_q.indis[6] && !s_q.outdis[7] && !s_q.outdis[6]
        |=> a_tx_enable_o[0] && b_tx_enable_o[0] && b_tx_from_a_o[0])
        else $error("lane 0 not broadcasting");

endmodule : rdcc_top
`default_nettype wire

// >>> tb/rdcc_host_model.sv
`default_nettype none
module rdcc_host_model (
    input wire logic mclk_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_ack_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [3:0] reg_idx_o,
    output logic [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_idx_o = 4'h0;
        reg_wdata_o = 8'h00;
    end
    // one-cycle request, answer looked at one edge later
    task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
        @(posedge mclk_i);
        #1;
        reg_wr_o = wr;
        reg_rd_o = !wr;
        reg_idx_o = idx;
        reg_wdata_o = wd;
        @(posedge mclk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        // released data flips so a stale byte is never mistaken for valid
        reg_wdata_o = ~wd;
        ok = reg_ack_i;
        rd = reg_rdata_i;
    endtask
endmodule // rdcc_host_model
`default_nettype wire

// >>> tb/tb.sv
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rdcc_pkg::*;
    logic mclk_i = 1'b0, nrst_i = 1'b0, mode = 1'b0, lb_n = 1'b1, pd_n = 1'b1, wa = 1'b0, wb = 1'b1;
    logic [1:0] lva = 2'h1, lvb = 2'h2, swa = 2'h1, swb = 2'h2;
    logic [2:0] eqa = 3'h2, eqb = 3'h5;
    logic [7:0] sig = 8'h00, rdata, wdata, rv, w;
    logic wr, rd, ack, ok;
    logic [3:0] idx;
    logic [23:0] eq;
    logic [1:0] sa, sb, la, lb;
    logic da, db, pdo, slo, byp;
    logic [7:0] vth, sq, ien;
    logic [3:0] atx, btx, bfa;
    int errors = 0, checks_done = 0, cyc = 0;
    initial forever #20 mclk_i = ~mclk_i;
    rdcc_host_model i_host (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_ack_i(ack), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_idx_o(idx), .reg_wdata_o(wdata));
    rdcc_top i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .mode_strap_i(mode), .loopback_strap_n_i(lb_n),
        .powerdown_strap_n_i(pd_n), .group_a_deemph_width_i(wa), .group_b_deemph_width_i(wb),
        .group_a_deemph_level_hi_i(lva[1]), .group_a_deemph_level_lo_i(lva[0]),
        .group_b_deemph_level_hi_i(lvb[1]), .group_b_deemph_level_lo_i(lvb[0]),
        .group_a_swing_hi_i(swa[1]), .group_a_swing_lo_i(swa[0]), .group_b_swing_hi_i(swb[1]),
        .group_b_swing_lo_i(swb[0]), .group_a_eq_sel_i(eqa), .group_b_eq_sel_i(eqb), .sig_detect_i(sig),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_idx_i(idx), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_ack_o(ack), .eq_code_o(eq), .group_a_swing_o(sa), .group_b_swing_o(sb),
        .group_a_deemph_level_o(la), .group_b_deemph_level_o(lb), .group_a_deemph_width_o(da),
        .group_b_deemph_width_o(db), .vth_sel_o(vth), .squelch_o(sq), .input_enable_o(ien),
        .a_tx_enable_o(atx), .b_tx_enable_o(btx), .b_tx_from_a_o(bfa), .powerdown_o(pdo),
        .slumber_en_o(slo), .bypass_o(byp));
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // cut a hang short well beyond the roughly 200 cycles the tests need
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    task automatic rst();
        @(posedge mclk_i);
        #1 nrst_i = 1'b0;
        repeat (4) @(posedge mclk_i);
        #1 nrst_i = 1'b1;
        repeat (12) @(posedge mclk_i);
    endtask
    task automatic wrr(input logic [3:0] i, input logic [7:0] d);
        i_host.xfer(1'b1, i, d, rv, ok);
        `CHK("wr ack", 1'b1, ok)
        repeat (4) @(posedge mclk_i);
        #1;
    endtask
    task automatic rdc(input logic [3:0] i, input logic [7:0] e);
        i_host.xfer(1'b0, i, 8'h00, rv, ok);
        `CHK("read", e, rv)
    endtask
    initial begin
        rst();
        rdc(4'h5, 8'h4A);
        rdc(4'h6, 8'hB4);
        rdc(4'h2, 8'hF6);
        rdc(4'hE, 8'h01);
        `CHK("eq", {4{3'h5, 3'h2}}, eq)
        `CHK("swing", {2'h1, 2'h2}, {sa, sb})
        `CHK("level", {2'h1, 2'h2}, {la, lb})
        `CHK("pd", 1'b0, pdo)
        $display("test capture done");
        wrr(4'h7, 8'h60);
        `CHK("eq a1", {3'h3, 3'h5, 3'h2}, eq[8:0])
        `CHK("swing a1", 2'h1, sa)
        for (int i = 0; i < 4; i++) begin
            wrr(4'h5, {3'h0, 2'(i), 2'(3 - i), 1'b0});
            `CHK("swing", 2'(3 - i), sa)
            `CHK("level", 2'(i), la)
        end
        rdc(4'hD, 8'h10);
        `CHK("vth", 8'h10, vth)
        wrr(4'hD, 8'h80);
        `CHK("vth", 8'h80, vth)
        $display("test registers done");
        mode = 1'b1;
        repeat (6) @(posedge mclk_i);
        #1;
        `CHK("eq", {8{3'h7}}, eq)
        `CHK("out", {2'h3, 2'h3, 2'h3, 2'h3, 1'b1, 1'b1}, {sa, sb, la, lb, da, db})
        i_host.xfer(1'b1, 4'hD, 8'h01, rv, ok);
        `CHK("ack", 1'b0, ok)
        mode = 1'b0;
        repeat (6) @(posedge mclk_i);
        rdc(4'hD, 8'h80);
        `CHK("swing back", 2'h0, sa)
        $display("test mode done");
        // {lb, in a, out a, in b, out b, a tx, b tx, b from a}
        for (int k = 0; k < 5; k++) begin
            w = (k == 0) ? 8'h86 : (k == 1) ? 8'h17 : (k == 2) ? 8'h33 : (k == 3) ? 8'h9C : 8'hE2;
            wrr(4'h2, {w[7], 3'b111, 4'b1000});
            wrr(4'h3, {w[6], w[4], 6'h00});
            wrr(4'h4, {w[5], w[3], 6'h00});
            `CHK("route", w[2:0], {atx[0], btx[0], bfa[0]})
            `CHK("inputs", {~w[4], ~w[6]}, ien[1:0])
            `CHK("other lanes", 3'h7, atx[3:1])
        end
        `CHK("width", {1'b1, 1'b0, 1'b0, 1'b0}, {da, db, slo, byp})
        $display("test routing done");
        sig = 8'h05;
        repeat (10) @(posedge mclk_i);
        #1;
        `CHK("squelch", 8'hFA, sq)
        rdc(4'h0, 8'hA0);
        $display("test squelch done");
        // loopback strap changed only across a reset
        lb_n = 1'b0;
        pd_n = 1'b0;
        rst();
        rdc(4'h2, 8'h06);
        rdc(4'hE, 8'h00);
        `CHK("pd", 1'b1, pdo)
        `CHK("lanes", 4'hF, atx)
        $display("test strap loopback done");
        end_sim();
    end
endmodule // tb
`default_nettype wire
